// >>> tcp_consts.svh
// Constants of the cascade, PWM and phase counting timer block
`ifndef TCP_CONSTS_SVH
`define TCP_CONSTS_SVH
`define TCP_NCH 6
`define TCP_NREG 4
`define TCP_NIN 28
`define TCP_CH_LIMIT 3'h6
`define TCP_ADDR_START 8'hC0
`define TCP_W_CTRL 3'h0
`define TCP_W_IOCTL 3'h1
`define TCP_W_STATUS 3'h2
`define TCP_W_COUNT 3'h3
`define TCP_W_GR0 3'h4
`define TCP_PSC_DIV1 3'h0
`define TCP_PSC_DIV4 3'h1
`define TCP_PSC_DIV16 3'h2
`define TCP_PSC_DIV64 3'h3
`define TCP_PSC_CASCADE 3'h7
`define TCP_DIV_W 6
`define TCP_CNT_MAX 16'hFFFF
`define TCP_CNT_ZERO 16'h0000
`define TCP_CNT_ONE 16'h0001
`define TCP_ST_OVF 4
`define TCP_ST_UNF 5
`define TCP_ST_DIR 7
`define TCP_ST_W1C 8'h3F
`define TCP_CLR_NONE 2'h0
`define TCP_LVL_NONE 2'h0
`define TCP_LVL_ZERO 2'h1
`define TCP_LVL_ONE 2'h2
`define TCP_LVL_TOG 2'h3
`define TCP_RST_CTRL 10'h000
`define TCP_RST_IO 16'h0000
`define TCP_RST_ST 8'h80
`define TCP_EXT_BASE 24
`define TCP_EXT_CD 26
`endif

// >>> tcp_pkg.sv
// Types of the cascade, PWM and phase counting timer block
package tcp_pkg;
   typedef enum logic [1:0] {
      TCP_MODE_NORMAL = 2'h0,
      TCP_MODE_PWM1 = 2'h1,
      TCP_MODE_PWM2 = 2'h3,
      TCP_MODE_PHASE = 2'h2
   } tcp_mode_t;
   typedef enum logic [1:0] {
      TCP_PH_1 = 2'h0,
      TCP_PH_2 = 2'h1,
      TCP_PH_3 = 2'h3,
      TCP_PH_4 = 2'h2
   } tcp_phase_t;
   typedef struct packed {
      logic bufEn;
      tcp_phase_t phaseSel;
      tcp_mode_t mode;
      logic [1:0] clrSel;
      logic [2:0] presc;
   } tcp_ctrl_t;
   typedef struct packed {
      logic capture;
      logic initLvl;
      logic [1:0] level;
   } tcp_pinsel_t;
endpackage : tcp_pkg

// >>> tcp_timer_cascade_pwm.sv
// Six-channel timer: capture buffering, cascade, PWM modes, phase counting
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`include "tcp_consts.svh"
module tcp_timer_cascade_pwm
   import tcp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic extClockInA,
   input wire logic extClockInB,
   input wire logic extClockInC,
   input wire logic extClockInD,
   input wire logic [23:0] timerPinIn,
   output logic [23:0] timerPinOut,
   output logic [23:0] timerPinOe
);
   function automatic logic applyLvl(input logic [1:0] lvl, input logic cur);
      case (lvl)
         `TCP_LVL_ZERO: applyLvl = 1'b0;
         `TCP_LVL_ONE: applyLvl = 1'b1;
         `TCP_LVL_TOG: applyLvl = ~cur;
         default: applyLvl = cur;
      endcase
   endfunction : applyLvl

   tcp_ctrl_t ctrl_q [`TCP_NCH];
   logic [15:0] ioctl_q [`TCP_NCH];
   logic [7:0] status_q [`TCP_NCH];
   logic [15:0] cnt_q [`TCP_NCH];
   logic [15:0] gr_q [`TCP_NCH][`TCP_NREG];
   logic [5:0] start_q;
   logic [`TCP_DIV_W-1:0] div_q;
   logic [`TCP_NIN-1:0] inMeta_q;
   logic [`TCP_NIN-1:0] inSync_q;
   logic [`TCP_NIN-1:0] inPrev_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [23:0] pinOut_q;
   logic [23:0] pinOe_q;
   logic [5:0] upTick;
   logic [5:0] downTick;
   logic [5:0] ovfEv;
   logic [5:0] unfEv;
   logic [5:0] clearEv;
   logic [5:0] isPhaseV;
   logic [5:0] phUpV;
   logic [5:0] phDnV;
   logic [5:0] cntWr;
   logic [3:0] matchEv [`TCP_NCH];
   logic [3:0] capEv [`TCP_NCH];
   logic [3:0] initV [`TCP_NCH];

   // Input synchroniser, then one stage for edge detection
   wire [`TCP_NIN-1:0] rawIn = {extClockInD, extClockInC, extClockInB, extClockInA, timerPinIn};
   wire [`TCP_NIN-1:0] inRise = inSync_q & ~inPrev_q;
   wire [`TCP_NIN-1:0] inFall = ~inSync_q & inPrev_q;
   always_ff @(posedge sys_clk)
   begin
      inMeta_q <= rawIn;
      inSync_q <= inMeta_q;
      inPrev_q <= inSync_q;
   end

   // Prescaler enables
   wire en4 = div_q[1:0] == 2'h0;
   wire en16 = div_q[3:0] == 4'h0;
   wire en64 = div_q == 6'h00;
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
         div_q <= 6'h00;
      else
         div_q <= div_q + 6'h01;
   end

   // APB slave: one wait state, then pready
   wire apbAccess = psel & penable;
   wire apbDone = apbAccess & pready_q;
   wire wr = apbDone & pwrite;
   wire [2:0] addrCh = paddr[7:5];
   wire [2:0] addrWord = paddr[4:2];
   wire isStart = paddr == `TCP_ADDR_START;
   wire chValid = (addrCh < `TCP_CH_LIMIT) & (paddr[1:0] == 2'h0);
   wire mapped = chValid | isStart;
   wire startWr = wr & isStart;
   wire [2:0] rdCh = chValid ? addrCh : 3'h0;
   logic [31:0] rdData;
   always_comb
   begin
      rdData = 32'h0000_0000;
      if (isStart)
         rdData = {26'h0, start_q};
      else if (chValid)
         case (addrWord)
            `TCP_W_CTRL: rdData = {22'h0, ctrl_q[rdCh]};
            `TCP_W_IOCTL: rdData = {16'h0, ioctl_q[rdCh]};
            `TCP_W_STATUS: rdData = {24'h0, status_q[rdCh]};
            `TCP_W_COUNT: rdData = {16'h0, cnt_q[rdCh]};
            default: rdData = {16'h0, gr_q[rdCh][addrWord[1:0]]};
         endcase
   end
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         start_q <= 6'h00;
      end
      else
      begin
         pready_q <= apbAccess & ~pready_q;
         pslverr_q <= apbAccess & ~pready_q & ~mapped;
         if (apbAccess & ~pready_q)
            prdata_q <= rdData;
         if (startWr)
            start_q <= pwdata[5:0];
      end
   end
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign timerPinOut = pinOut_q;
   assign timerPinOe = pinOe_q;

   for (genvar ch = 0; ch < `TCP_NCH; ch++)
   begin : g_ch
      localparam bit PHASE_OK = (ch == 1) || (ch == 2) || (ch == 4) || (ch == 5);
      localparam bit UPPER = (ch == 1) || (ch == 4);
      localparam int PA = ((ch == 1) || (ch == 5)) ? `TCP_EXT_BASE : `TCP_EXT_CD;
      localparam int PB = PA + 1;
      tcp_ctrl_t c;
      tcp_pinsel_t fs [`TCP_NREG];
      logic phUp;
      logic phDn;
      logic presTick;
      logic lowOvf;
      logic lowUnf;
      logic dir_q;
      wire chWr = wr & chValid & (addrCh == ch);
      assign c = ctrl_q[ch];
      assign cntWr[ch] = chWr & (addrWord == `TCP_W_COUNT);
      wire isPhase = PHASE_OK && (c.mode == TCP_MODE_PHASE);
      assign isPhaseV[ch] = isPhase;
      assign phUpV[ch] = phUp;
      assign phDnV[ch] = phDn;
      // Encoder phase pins per channel
      wire aH = inSync_q[PA];
      wire bH = inSync_q[PB];
      wire aR = inRise[PA];
      wire aF = inFall[PA];
      wire bR = inRise[PB];
      wire bF = inFall[PB];
      always_comb
      begin
         phUp = 1'b0;
         phDn = 1'b0;
         case (c.phaseSel)
            TCP_PH_1:
            begin
               phUp = (aH & bR) | (~aH & bF) | (aR & ~bH) | (aF & bH);
               phDn = (aH & bF) | (~aH & bR) | (aR & bH) | (aF & ~bH);
            end
            TCP_PH_2:
            begin
               phUp = aF & bH;
               phDn = aR & ~bH;
            end
            TCP_PH_3:
            begin
               phUp = aF & bH;
               phDn = aH & bF;
            end
            TCP_PH_4:
            begin
               phUp = (aH & bR) | (~aH & bF);
               phDn = (aH & bF) | (~aH & bR);
            end
            default:
            begin
               phUp = 1'b0;
               phDn = 1'b0;
            end
         endcase
      end
      always_comb
      begin
         case (c.presc)
            `TCP_PSC_DIV1: presTick = 1'b1;
            `TCP_PSC_DIV4: presTick = en4;
            `TCP_PSC_DIV16: presTick = en16;
            `TCP_PSC_DIV64: presTick = en64;
            default: presTick = 1'b0;
         endcase
      end
      if (UPPER)
      begin : g_up
         assign lowOvf = ovfEv[ch+1];
         assign lowUnf = unfEv[ch+1];
      end
      else
      begin : g_noup
         assign lowOvf = 1'b0;
         assign lowUnf = 1'b0;
      end
      wire cascSel = UPPER && (c.presc == `TCP_PSC_CASCADE);
      // Phase mode overrides prescaler and cascade choice
      assign upTick[ch] = start_q[ch] & (isPhase ? phUp : cascSel ? lowOvf : presTick);
      assign downTick[ch] = start_q[ch] & (isPhase ? phDn : cascSel & lowUnf);
      wire anyTick = upTick[ch] | downTick[ch];
      wire [1:0] perIdx = c.clrSel - 2'h1;
      wire [3:0] hitEv = matchEv[ch] | capEv[ch];
      assign clearEv[ch] = (c.clrSel != `TCP_CLR_NONE) & hitEv[perIdx];
      wire atMax = cnt_q[ch] == `TCP_CNT_MAX;
      wire atZero = cnt_q[ch] == `TCP_CNT_ZERO;
      assign ovfEv[ch] = upTick[ch] & atMax & ~clearEv[ch];
      assign unfEv[ch] = isPhase & downTick[ch] & atZero & ~clearEv[ch];
      logic [15:0] cnt_d;
      always_comb
      begin
         cnt_d = cnt_q[ch];
         if (cntWr[ch])
            cnt_d = pwdata[15:0];
         else if (clearEv[ch])
            cnt_d = `TCP_CNT_ZERO;
         else if (upTick[ch])
            cnt_d = cnt_q[ch] + `TCP_CNT_ONE;
         else if (downTick[ch])
            cnt_d = cnt_q[ch] - `TCP_CNT_ONE;
      end
      // Status: set wins over write-one-to-clear; direction shown in step with the counter
      wire dirD = anyTick ? upTick[ch] : dir_q;
      wire [7:0] stSet = {1'b0, 1'b0, unfEv[ch], ovfEv[ch], hitEv};
      wire [7:0] stClr = (chWr & (addrWord == `TCP_W_STATUS)) ? (pwdata[7:0] & `TCP_ST_W1C) : 8'h00;
      wire [7:0] stD = (((status_q[ch] & ~stClr) | stSet) & `TCP_ST_W1C) | {dirD, 7'h00};
      always_ff @(posedge sys_clk)
      begin
         if (sys_rst)
         begin
            ctrl_q[ch] <= `TCP_RST_CTRL;
            ioctl_q[ch] <= `TCP_RST_IO;
            cnt_q[ch] <= `TCP_CNT_ZERO;
            status_q[ch] <= `TCP_RST_ST;
            dir_q <= 1'b1;
         end
         else
         begin
            if (chWr & (addrWord == `TCP_W_CTRL))
               ctrl_q[ch] <= pwdata[9:0];
            if (chWr & (addrWord == `TCP_W_IOCTL))
               ioctl_q[ch] <= pwdata[15:0];
            cnt_q[ch] <= cnt_d;
            dir_q <= dirD;
            status_q[ch] <= stD;
         end
      end
      for (genvar r = 0; r < `TCP_NREG; r++)
      begin : g_reg
         localparam int PIN = ch * `TCP_NREG + r;
         localparam int MATE = r ^ 1;
         localparam logic [1:0] RIDX = 2'(r);
         tcp_pinsel_t f;
         logic pin_d;
         logic oe_d;
         logic [15:0] gr_d;
         assign f = ioctl_q[ch][r*4 +: 4];
         assign fs[r] = f;
         assign initV[ch][r] = f.initLvl;
         wire edgeHit = (f.level[0] & inRise[PIN]) | (f.level[1] & inFall[PIN]);
         assign capEv[ch][r] = f.capture & edgeHit;
         assign matchEv[ch][r] = anyTick & ~f.capture & (cnt_q[ch] == gr_q[ch][r]);
         wire grWr = chWr & (addrWord == (`TCP_W_GR0 + {1'b0, RIDX}));
         if (r >= 2)
         begin : g_buf
            wire bufMove = c.bufEn & capEv[ch][r-2];
            always_comb
            begin
               gr_d = gr_q[ch][r];
               if (capEv[ch][r])
                  gr_d = cnt_q[ch];
               else if (bufMove)
                  gr_d = gr_q[ch][r-2];
               else if (grWr)
                  gr_d = pwdata[15:0];
            end
         end
         else
         begin : g_nobuf
            always_comb
            begin
               gr_d = gr_q[ch][r];
               if (capEv[ch][r])
                  gr_d = cnt_q[ch];
               else if (grWr)
                  gr_d = pwdata[15:0];
            end
         end
         // Pin level per mode
         wire cur = pinOut_q[PIN];
         wire pairSame = gr_q[ch][r] == gr_q[ch][MATE];
         wire perSame = gr_q[ch][r] == gr_q[ch][perIdx];
         wire isPer = (c.clrSel != `TCP_CLR_NONE) && (perIdx == RIDX);
         always_comb
         begin
            pin_d = cur;
            oe_d = ~f.capture & (f.level != `TCP_LVL_NONE);
            case (c.mode)
               TCP_MODE_PWM1:
               begin
                  oe_d = (r % 2) == 0;
                  if ((r % 2) == 0)
                  begin
                     if (!start_q[ch])
                        pin_d = f.initLvl;
                     else if (matchEv[ch][r] & ~pairSame)
                        pin_d = applyLvl(f.level, cur);
                     else if (matchEv[ch][MATE] & ~pairSame)
                        pin_d = applyLvl(fs[MATE].level, cur);
                  end
               end
               TCP_MODE_PWM2:
               begin
                  oe_d = ~f.capture & ~isPer;
                  if (!start_q[ch] | clearEv[ch])
                     pin_d = f.initLvl;
                  else if (matchEv[ch][r] & ~perSame & ~isPer)
                     pin_d = applyLvl(f.level, cur);
               end
               default:
               begin
                  if (!start_q[ch])
                     pin_d = f.initLvl;
                  else if (matchEv[ch][r])
                     pin_d = applyLvl(f.level, cur);
               end
            endcase
         end
         always_ff @(posedge sys_clk)
         begin
            if (sys_rst)
            begin
               gr_q[ch][r] <= `TCP_CNT_MAX;
               pinOut_q[PIN] <= 1'b0;
               pinOe_q[PIN] <= 1'b0;
            end
            else
            begin
               gr_q[ch][r] <= gr_d;
               pinOut_q[PIN] <= pin_d;
               pinOe_q[PIN] <= oe_d;
            end
         end
      end
   end

   // Checks
   sequence s_carry;
      ovfEv[2] && start_q[1] && (ctrl_q[1].presc == `TCP_PSC_CASCADE) && !isPhaseV[1] && !clearEv[1] && !cntWr[1];
   endsequence
   sequence s_borrow;
      unfEv[5] && start_q[4] && (ctrl_q[4].presc == `TCP_PSC_CASCADE) && !isPhaseV[4] && !clearEv[4] && !cntWr[4];
   endsequence
   property p_cascade_up;
      @(posedge sys_clk) disable iff (sys_rst) s_carry |=> cnt_q[1] == $past(cnt_q[1]) + `TCP_CNT_ONE;
   endproperty
   a_cascade_up: assert property (p_cascade_up) else $error("upper counter missed carry");
   property p_cascade_down;
      @(posedge sys_clk) disable iff (sys_rst) s_borrow |=> cnt_q[4] == $past(cnt_q[4]) - `TCP_CNT_ONE;
   endproperty
   a_cascade_down: assert property (p_cascade_down) else $error("upper counter missed borrow");
   property p_buffer;
      @(posedge sys_clk) disable iff (sys_rst)
         capEv[0][0] && ctrl_q[0].bufEn && !capEv[0][2] |=> gr_q[0][2] == $past(gr_q[0][0]) && gr_q[0][0] == $past(cnt_q[0]);
   endproperty
   a_buffer: assert property (p_buffer) else $error("capture buffer not moved");
   property p_unf_phase;
      @(posedge sys_clk) disable iff (sys_rst)
         unfEv[5] && !cntWr[5] |-> isPhaseV[5] ##1 status_q[5][`TCP_ST_UNF] && cnt_q[5] == `TCP_CNT_MAX;
   endproperty
   a_unf_phase: assert property (p_unf_phase) else $error("underflow outside phase mode");
   property p_ovf_flag;
      @(posedge sys_clk) disable iff (sys_rst) ovfEv[4] |=> status_q[4][`TCP_ST_OVF] && cnt_q[4] != `TCP_CNT_MAX;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");
   property p_dir;
      @(posedge sys_clk) disable iff (sys_rst) downTick[1] |=> !status_q[1][`TCP_ST_DIR] ##1 !status_q[1][`TCP_ST_DIR] || $past(upTick[1]);
   endproperty
   a_dir: assert property (p_dir) else $error("direction flag wrong");
   property p_pwm1_same;
      @(posedge sys_clk) disable iff (sys_rst)
         ctrl_q[0].mode == TCP_MODE_PWM1 && start_q[0] && !startWr && matchEv[0][0] && gr_q[0][0] == gr_q[0][1]
         |=> pinOut_q[0] == $past(pinOut_q[0]);
   endproperty
   a_pwm1_same: assert property (p_pwm1_same) else $error("pwm1 pin moved on equal pair");
   property p_pwm2_clear;
      @(posedge sys_clk) disable iff (sys_rst)
         ctrl_q[3].mode == TCP_MODE_PWM2 && clearEv[3] |=> pinOut_q[15:12] == $past(initV[3]);
   endproperty
   a_pwm2_clear: assert property (p_pwm2_clear) else $error("pwm2 pins not reset at period");
   property p_phase_src;
      @(posedge sys_clk) disable iff (sys_rst)
         isPhaseV[1] && start_q[1] && !phUpV[1] && !phDnV[1] && !clearEv[1] && !cntWr[1]
         |=> cnt_q[1] == $past(cnt_q[1]);
   endproperty
   a_phase_src: assert property (p_phase_src) else $error("phase channel used clock choice");
endmodule : tcp_timer_cascade_pwm

// >>> tcp_enc_model.sv
// Two-phase encoder that drives one pair of external clock inputs
`timescale 1ns/10ps
module tcp_enc_model
(
   input wire logic sys_clk,
   input wire logic stepUp,
   input wire logic stepDn,
   output logic phaseA,
   output logic phaseB
);
   logic [1:0] pos_q = 2'h0;
   // Gray position: A leads B when moving up, one edge per step
   assign phaseA = pos_q[1] ^ pos_q[0];
   assign phaseB = pos_q[1];
   always_ff @(posedge sys_clk)
   begin
      if (stepUp)
         pos_q <= pos_q + 2'h1;
      else if (stepDn)
         pos_q <= pos_q - 2'h1;
   end
endmodule : tcp_enc_model

// >>> tcp_timer_cascade_pwm_tb.sv
// Self-checking bench for the cascade, PWM and phase counting timer
`timescale 1ns/10ps
module tcp_timer_cascade_pwm_tb
   import tcp_pkg::*;
;
   localparam logic [31:0] allBits = 32'hFFFFFFFF;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] encUp = 2'h0;
   logic [1:0] encDn = 2'h0;
   wire [3:0] ext;
   logic [23:0] timerPinIn = 24'h000000;
   logic [23:0] timerPinOut;
   logic [23:0] timerPinOe;
   logic [31:0] rdv;
   logic [31:0] v1;
   logic err;
   int n;
   int n_fail = 0;
   int tests_run = 0;

   always #50 sys_clk = ~sys_clk;

   tcp_timer_cascade_pwm DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .extClockInA(ext[0]), .extClockInB(ext[1]), .extClockInC(ext[2]), .extClockInD(ext[3]),
      .timerPinIn(timerPinIn), .timerPinOut(timerPinOut), .timerPinOe(timerPinOe));
   tcp_enc_model encAB (.sys_clk(sys_clk), .stepUp(encUp[0]), .stepDn(encDn[0]), .phaseA(ext[0]),
      .phaseB(ext[1]));
   tcp_enc_model encCD (.sys_clk(sys_clk), .stepUp(encUp[1]), .stepDn(encDn[1]), .phaseA(ext[2]),
      .phaseB(ext[3]));

   task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic e);
      int i;
      i = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge sys_clk);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      if (i >= 50)
         check("pready", 32'h1, 32'h0);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdv, err);
   endtask : wr

   task rchk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      apb(1'b0, a, 32'h00000000, rdv, err);
      check(nm, exp, rdv & m);
   endtask : rchk

   task hi_cnt(input int b);
      n = 0;
      repeat (100)
      begin
         @(posedge sys_clk);
         if (timerPinOut[b] === 1'b1)
            n++;
      end
   endtask : hi_cnt

   task pulse(input logic [23:0] m);
      @(posedge sys_clk);
      timerPinIn <= m;
      repeat (6) @(posedge sys_clk);
      timerPinIn <= 24'h000000;
      repeat (6) @(posedge sys_clk);
   endtask : pulse

   task enc(input int k, input logic up, input int cnt);
      repeat (cnt)
      begin
         @(posedge sys_clk);
         encUp[k] <= up;
         encDn[k] <= !up;
         @(posedge sys_clk);
         encUp[k] <= 1'b0;
         encDn[k] <= 1'b0;
         repeat (8) @(posedge sys_clk);
      end
   endtask : enc

   task t_regs;
      rchk("ctrl rst", 8'h00, 32'h00000000, allBits);
      rchk("status rst", 8'h08, 32'h00000080, allBits);
      rchk("count rst", 8'h0C, 32'h00000000, allBits);
      rchk("reg a rst", 8'h10, 32'h0000FFFF, allBits);
      wr(8'h00, allBits);
      rchk("ctrl rw", 8'h00, 32'h000003FF, allBits);
      wr(8'h00, 32'h00000000);
      apb(1'b0, 8'hE0, 32'h00000000, rdv, err);
      check("unmapped err", 32'h1, {31'h0, err});
      check("unmapped data", 32'h0, rdv);
      apb(1'b1, 8'h02, 32'h00000000, rdv, err);
      check("misaligned err", 32'h1, {31'h0, err});
      $display("test regs done");
   endtask : t_regs

   task t_pwm1;
      wr(8'h00, 32'h00000028);
      wr(8'h04, 32'h00000025);
      wr(8'h10, 32'h00000009);
      wr(8'h14, 32'h00000003);
      repeat (2) @(posedge sys_clk);
      check("pwm1 initial", 32'h1, {31'h0, timerPinOut[0]});
      wr(8'hC0, 32'h00000001);
      repeat (20) @(posedge sys_clk);
      hi_cnt(0);
      check("pwm1 high", 32'h3C, n);
      check("pwm1 oe a", 32'h1, {31'h0, timerPinOe[0]});
      check("pwm1 oe b", 32'h0, {31'h0, timerPinOe[1]});
      wr(8'h14, 32'h00000009);
      repeat (20) @(posedge sys_clk);
      hi_cnt(0);
      check("pwm1 equal", 32'h1, {31'h0, n == 0 || n == 100});
      $display("test pwm1 done");
   endtask : t_pwm1

   task t_pwm2;
      wr(8'h60, 32'h00000070);
      wr(8'h64, 32'h00005202);
      wr(8'h70, 32'h00000004);
      wr(8'h74, 32'h00000009);
      wr(8'h78, 32'h00000009);
      wr(8'h7C, 32'h00000006);
      check("pwm2 initial", 32'h1, {31'h0, timerPinOut[15]});
      wr(8'hC0, 32'h00000008);
      repeat (20) @(posedge sys_clk);
      hi_cnt(12);
      check("pwm2 pin a", 32'h32, n);
      hi_cnt(14);
      check("pwm2 pin c", 32'h0, n);
      hi_cnt(15);
      check("pwm2 pin d", 32'h46, n);
      check("pwm2 oe a", 32'h1, {31'h0, timerPinOe[12]});
      check("pwm2 oe b", 32'h0, {31'h0, timerPinOe[13]});
      $display("test pwm2 done");
   endtask : t_pwm2

   task t_buf;
      wr(8'hC0, 32'h00000000);
      wr(8'h00, 32'h00000200);
      wr(8'h04, 32'h00000009);
      wr(8'h0C, 32'h00000000);
      wr(8'hC0, 32'h00000001);
      repeat (10) @(posedge sys_clk);
      pulse(24'h000001);
      apb(1'b0, 8'h10, 32'h00000000, v1, err);
      check("capture a", 32'h1, {31'h0, v1 < 32'h0000FFFF});
      pulse(24'h000001);
      rchk("buffer c", 8'h18, v1, allBits);
      apb(1'b0, 8'h10, 32'h00000000, rdv, err);
      check("capture newer", 32'h1, {31'h0, rdv > v1});
      $display("test buffer done");
   endtask : t_buf

   task t_cascap;
      wr(8'hC0, 32'h00000000);
      wr(8'h20, 32'h00000007);
      wr(8'h40, 32'h00000000);
      wr(8'h24, 32'h00000009);
      wr(8'h44, 32'h00000009);
      wr(8'h4C, 32'h0000FFF0);
      wr(8'h2C, 32'h00000005);
      wr(8'hC0, 32'h00000006);
      repeat (30) @(posedge sys_clk);
      pulse(24'h000110);
      rchk("upper half", 8'h30, 32'h00000006, allBits);
      apb(1'b0, 8'h50, 32'h00000000, v1, err);
      check("lower half", 32'h1, {31'h0, v1 < 32'h00000040});
      rchk("no underflow", 8'h48, 32'h00000000, 32'h00000020);
      $display("test cascade capture done");
   endtask : t_cascap

   task t_phase;
      wr(8'hC0, 32'h00000000);
      wr(8'h20, 32'h00000047);
      wr(8'h40, 32'h00000040);
      wr(8'h80, 32'h00000007);
      wr(8'hA0, 32'h00000040);
      wr(8'h2C, 32'h00000000);
      wr(8'h4C, 32'h00000000);
      wr(8'h8C, 32'h00000000);
      wr(8'hAC, 32'h00000000);
      wr(8'h48, 32'h0000003F);
      wr(8'hA8, 32'h0000003F);
      wr(8'hC0, 32'h00000036);
      enc(0, 1'b0, 3);
      enc(1, 1'b0, 1);
      rchk("ch5 down", 8'hAC, 32'h0000FFFD, allBits);
      rchk("ch4 borrow", 8'h8C, 32'h0000FFFF, allBits);
      rchk("ch1 own", 8'h2C, 32'h0000FFFD, allBits);
      rchk("ch2 down", 8'h4C, 32'h0000FFFF, allBits);
      rchk("ch5 st down", 8'hA8, 32'h00000020, 32'h000000B0);
      rchk("ch2 st down", 8'h48, 32'h00000020, 32'h000000B0);
      enc(0, 1'b1, 3);
      rchk("ch5 wrap", 8'hAC, 32'h00000000, allBits);
      rchk("ch4 carry", 8'h8C, 32'h00000000, allBits);
      rchk("ch1 up", 8'h2C, 32'h00000000, allBits);
      rchk("ch5 st up", 8'hA8, 32'h000000B0, 32'h000000B0);
      $display("test phase cascade done");
   endtask : t_phase

   task tally_and_finish;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      $display("[ERR] watchdog expected done seen hang");
      tally_and_finish;
   end

   initial
   begin
      repeat (8) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_regs;
      t_pwm1;
      t_pwm2;
      t_buf;
      t_cascap;
      t_phase;
      tally_and_finish;
   end
endmodule : tcp_timer_cascade_pwm_tb
